// [rtl/serial_program_download.sv]
// serial in-system programming port with its flash, eeprom and fuses
// assumes sck is a clock that stops between frames and that the
// reset pin level arrives unsynchronised from the board
`timescale 1ns/1ps
`include "isp_defs.svh"

module serial_program_download #(
    parameter int FLASH_WAIT_CYC = `FLASH_WAIT_US * `SYS_MHZ,
    parameter int FUSE_WAIT_CYC  = `FUSE_WAIT_US * `SYS_MHZ,
    parameter int EEP_WAIT_CYC   = `EEP_WAIT_US * `SYS_MHZ,
    parameter int ERASE_WAIT_CYC = `ERASE_WAIT_US * `SYS_MHZ,
    // identity bytes: values are arbitrary
    parameter logic [7:0] SIG_0  = 8'h5a,
    parameter logic [7:0] SIG_1  = 8'h01,
    parameter logic [7:0] SIG_2  = 8'h02,
    parameter logic [7:0] CAL    = 8'h80,
    parameter logic [7:0] LOCK_INIT = 8'hff,
    parameter logic [7:0] FLO_INIT  = 8'hff,
    parameter logic [7:0] FHI_INIT  = 8'hff,
    parameter logic [7:0] FEXT_INIT = 8'hff
) (
    // system side
    input  wire logic sys_clk,
    input  wire logic reset,
    input  wire logic ce,
    // programming pins
    input  wire logic prog_reset_n,
    input  wire logic sck,
    input  wire logic mosi,
    output logic      miso,
    // status
    output logic      prog_enabled,
    output logic      pending_operation_flag,
    // configuration bytes, zero bit means programmed
    output logic [7:0] lock_bits,
    output logic [7:0] fuse_low,
    output logic [7:0] fuse_high,
    output logic [7:0] fuse_ext
);

    logic [31:0] sh_q, frm_q;
    logic [23:0] hdr_q;
    logic [4:0]  bc_q;
    logic        hdr_tg_q, frm_tg_q;
    logic [7:0]  out_q, ans_q;
    logic [2:0]  sy1_q, sy2_q;
    logic [1:0]  sy3_q;
    logic        link_rst, pin_hi, hdr_ev, frm_ev, go, busy;
    logic        prog_en_q, busy_q;
    isp_pkg::isp_state_t st_q;
    logic [12:0] idx_q;
    logic [6:0]  page_q;
    logic [20:0] tmr_q;
    logic [7:0]  lock_q, flo_q, fhi_q, fext_q;
    logic [7:0]  fl_lo [`FL_WORDS];
    logic [7:0]  fl_hi [`FL_WORDS];
    logic [7:0]  ee    [`EE_BYTES];
    logic [7:0]  pb_lo [`PG_WORDS];
    logic [7:0]  pb_hi [`PG_WORDS];
    logic [7:0]  eb    [4];
    logic [3:0]  emask_q;
    logic [7:0]  h_op, h_b2, h_b3, f_op, f_b2, f_b3, f_d;
    logic [12:0] h_fa, f_fa;
    logic [9:0]  h_ea, f_ea;

    // link logic is held in reset while the reset pin is high
    assign pin_hi   = sy2_q[0]; // pin is active low: high ends programming
    assign link_rst = reset | pin_hi;

    // shift register and bit counter, sampled on rising sck
    always_ff @(posedge sck or posedge link_rst) begin
        if (link_rst) begin
            sh_q <= '0;
            bc_q <= '0;
        end else begin
            sh_q <= {sh_q[30:0], mosi};
            bc_q <= bc_q + 5'd1;       // wraps every four bytes
        end
    end

    // capture of header and whole frame, each flagged by a toggle
    always_ff @(posedge sck or posedge link_rst) begin
        if (link_rst) begin
            hdr_q    <= '0;
            frm_q    <= '0;
            hdr_tg_q <= 1'b0;
            frm_tg_q <= 1'b0;
        end else begin
            if (bc_q == `BIT_HDR_LAST) begin
                hdr_q    <= {sh_q[22:0], mosi};
                hdr_tg_q <= ~hdr_tg_q;
            end
            if (bc_q == `BIT_FRM_LAST) begin
                frm_q    <= {sh_q[30:0], mosi};
                frm_tg_q <= ~frm_tg_q;
            end
        end
    end

    // output shifter on falling sck; ans_q is settled by the time
    // byte four starts only because the sck high phase is long
    always_ff @(negedge sck or posedge link_rst) begin
        if (link_rst) begin
            out_q <= '0;
        end else if (bc_q == `BIT_B2_END) begin
            out_q <= sh_q[7:0];
        end else if (bc_q == `BIT_B3_END) begin
            out_q <= ans_q;
        end else begin
            out_q <= {out_q[6:0], 1'b0};
        end
    end
    assign miso = out_q[7];

    // synchronisers: pin level, header toggle, frame toggle
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            sy1_q <= 3'h1;
            sy2_q <= 3'h1;
            sy3_q <= '0;
        end else if (ce) begin
            sy1_q <= {frm_tg_q, hdr_tg_q, prog_reset_n};
            sy2_q <= sy1_q;
            sy3_q <= sy2_q[2:1];
        end
    end
    assign hdr_ev = sy2_q[1] ^ sy3_q[0];
    assign frm_ev = sy2_q[2] ^ sy3_q[1];

    assign h_op = hdr_q[23:16];
    assign h_b2 = hdr_q[15:8];
    assign h_b3 = hdr_q[7:0];
    assign h_fa = {h_b2[4:0], h_b3};
    assign h_ea = {h_b2[1:0], h_b3};
    assign f_op = frm_q[31:24];
    assign f_b2 = frm_q[23:16];
    assign f_b3 = frm_q[15:8];
    assign f_d  = frm_q[7:0];
    assign f_fa = {f_b2[4:0], f_b3};
    assign f_ea = {f_b2[1:0], f_b3};

    assign busy = (st_q != isp_pkg::ST_IDLE) || (tmr_q != '0);
    // a frame other than the enable frame acts only when enabled and idle; poll and reads always answer
    assign go = ce & frm_ev & prog_en_q & ~busy & ~pin_hi;

    // byte-four answer, chosen once three bytes have arrived
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            ans_q <= '0;
        end else if (ce && hdr_ev) begin
            case (h_op)
                `OP_POLL:    ans_q <= {7'h00, busy};
                `OP_RD_HI:   ans_q <= fl_hi[h_fa];
                `OP_RD_LO:   ans_q <= fl_lo[h_fa];
                `OP_RD_EEP:  ans_q <= ee[h_ea];
                `OP_RD_LOCK: ans_q <= (h_b2 == `B2_FUSE_SEL) ?
                                      fhi_q : lock_q;
                `OP_RD_FUSE: ans_q <= (h_b2 == `B2_FUSE_SEL) ?
                                      fext_q : flo_q;
                `OP_RD_SIG:  ans_q <= (h_b3[1:0] == 2'h0) ? SIG_0 :
                                      (h_b3[1:0] == 2'h1) ? SIG_1 :
                                      (h_b3[1:0] == 2'h2) ? SIG_2 :
                                      `BYTE_ERASED;
                `OP_RD_CAL:  ans_q <= CAL;
                default:     ans_q <= `BYTE_ZERO;
            endcase
        end
    end

    // enable flag: set by the enable frame, dropped by the reset pin
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            prog_en_q <= 1'b0;
        end else if (ce) begin
            if (pin_hi) begin
                prog_en_q <= 1'b0;
            end else if (frm_ev && f_op == `OP_CFG &&
                         f_b2 == `B2_ENABLE) begin
                prog_en_q <= 1'b1;
            end
        end
    end

    // self-timed operations: erase walk, page copy and wait timer
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            st_q   <= isp_pkg::ST_IDLE;
            idx_q  <= '0;
            page_q <= '0;
            tmr_q  <= '0;
        end else if (ce) begin
            if (tmr_q != '0) begin
                tmr_q <= tmr_q - 21'd1;
            end
            unique case (st_q)
                isp_pkg::ST_IDLE: begin
                    idx_q <= '0;
                    if (go && f_op == `OP_CFG && f_b2 == `B2_ERASE) begin
                        st_q  <= isp_pkg::ST_ERASE;
                        tmr_q <= 21'(ERASE_WAIT_CYC);
                    end else if (go && f_op == `OP_CFG &&
                                 (f_b2 == `B2_LOCK ||
                                  f_b2 == `B2_FUSE_LO ||
                                  f_b2 == `B2_FUSE_HI ||
                                  f_b2 == `B2_FUSE_EXT)) begin
                        tmr_q <= 21'(FUSE_WAIT_CYC);
                    end else if (go && f_op == `OP_WR_PAGE) begin
                        st_q   <= isp_pkg::ST_FCOPY;
                        page_q <= f_fa[12:6];
                        tmr_q  <= 21'(FLASH_WAIT_CYC);
                    end else if (go && (f_op == `OP_WR_EEP ||
                                        f_op == `OP_WR_EPAGE)) begin
                        tmr_q <= 21'(EEP_WAIT_CYC);
                    end
                end
                isp_pkg::ST_ERASE: begin
                    idx_q <= idx_q + 13'd1;
                    if (idx_q == `ERASE_LAST) begin
                        st_q <= isp_pkg::ST_IDLE;
                    end
                end
                isp_pkg::ST_FCOPY: begin
                    idx_q <= idx_q + 13'd1;
                    if (idx_q[5:0] == `PG_LAST) begin
                        st_q <= isp_pkg::ST_IDLE;
                    end
                end
            endcase
        end
    end

    // lock and fuse bytes; lock bits only go back to ones through chip erase
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            lock_q <= LOCK_INIT;
            flo_q  <= FLO_INIT;
            fhi_q  <= FHI_INIT;
            fext_q <= FEXT_INIT;
        end else if (go && f_op == `OP_CFG) begin
            unique case (f_b2)
                `B2_ERASE:    lock_q <= `BYTE_ERASED;
                `B2_LOCK:     lock_q <= lock_q & f_d;
                `B2_FUSE_LO:  flo_q  <= f_d;
                `B2_FUSE_HI:  fhi_q  <= f_d;
                `B2_FUSE_EXT: fext_q <= f_d;
                default:      lock_q <= lock_q;
            endcase
        end
    end

    // flash page buffer, one byte per frame; 4d needs no state here
    // because the whole array fits the 13-bit word address
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            for (int i = 0; i < `PG_WORDS; i++) begin
                pb_lo[i] <= `BYTE_ERASED;
                pb_hi[i] <= `BYTE_ERASED;
            end
        end else if (go && f_op == `OP_LD_LO) begin
            pb_lo[f_b3[5:0]] <= f_d;
        end else if (go && f_op == `OP_LD_HI) begin
            pb_hi[f_b3[5:0]] <= f_d;
        end
    end

    // eeprom page buffer with a mask of the bytes loaded
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            emask_q <= '0;
            for (int i = 0; i < 4; i++) begin
                eb[i] <= `BYTE_ZERO;
            end
        end else if (go && f_op == `OP_LD_EEP) begin
            eb[f_b3[1:0]]      <= f_d;
            emask_q[f_b3[1:0]] <= 1'b1;
        end else if (go && f_op == `OP_WR_EPAGE) begin
            emask_q <= '0;
        end
    end

    // flash array: erase walk or page copy, one word per cycle
    always_ff @(posedge sys_clk) begin
        if (ce && st_q == isp_pkg::ST_ERASE) begin
            fl_lo[idx_q] <= `BYTE_ERASED;
            fl_hi[idx_q] <= `BYTE_ERASED;
        end else if (ce && st_q == isp_pkg::ST_FCOPY) begin
            fl_lo[{page_q, idx_q[5:0]}] <= pb_lo[idx_q[5:0]];
            fl_hi[{page_q, idx_q[5:0]}] <= pb_hi[idx_q[5:0]];
        end
    end

    // eeprom array: erase walk, byte write, masked page write
    always_ff @(posedge sys_clk) begin
        if (ce && st_q == isp_pkg::ST_ERASE && idx_q[12:10] == 3'h0) begin
            ee[idx_q[9:0]] <= `BYTE_ERASED;
        end else if (go && f_op == `OP_WR_EEP) begin
            ee[f_ea] <= f_d;
        end else if (go && f_op == `OP_WR_EPAGE) begin
            for (int k = 0; k < 4; k++) begin
                if (emask_q[k]) begin
                    ee[{f_ea[9:2], 2'(k)}] <= eb[k];
                end
            end
        end
    end

    // registered status outputs
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            busy_q <= 1'b0;
        end else if (ce) begin
            busy_q <= busy;
        end
    end
    assign prog_enabled           = prog_en_q;
    assign pending_operation_flag = busy_q;
    assign lock_bits              = lock_q;
    assign fuse_low               = flo_q;
    assign fuse_high              = fhi_q;
    assign fuse_ext               = fext_q;

    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);

    // no operation starts before the enable frame
    a_enable_gate: assert property (
        (ce && frm_ev && !prog_en_q && !busy) |=> !busy)
        else $error("operation started without enable");
    a_pin_drop: assert property (
        (ce && pin_hi) |=> !prog_en_q)
        else $error("enable kept with reset pin high");
    a_poll_status: assert property (
        (ce && hdr_ev && h_op == `OP_POLL) |=> ans_q == {7'h00, $past(busy)})
        else $error("poll answer wrong");
    a_flash_busy: assert property (
        (go && f_op == `OP_WR_PAGE) |=>
        (st_q == isp_pkg::ST_FCOPY && tmr_q == 21'(FLASH_WAIT_CYC))
        ##1 busy [*7])
        else $error("page commit timing wrong");
    a_eep_wait: assert property (
        (go && f_op == `OP_WR_EEP) |=>
        (tmr_q == 21'(EEP_WAIT_CYC) && ee[f_ea] == f_d))
        else $error("eeprom write wrong");
    a_erase_start: assert property (
        (go && f_op == `OP_CFG && f_b2 == `B2_ERASE) |=>
        (lock_q == `BYTE_ERASED && st_q == isp_pkg::ST_ERASE))
        else $error("chip erase did not start");
    a_lock_and: assert property (
        (go && f_op == `OP_CFG && f_b2 == `B2_LOCK) |=>
        lock_q == ($past(lock_q) & $past(f_d)))
        else $error("lock bits not anded");
    a_page_load: assert property (
        (go && f_op == `OP_LD_LO) |=> pb_lo[f_b3[5:0]] == f_d)
        else $error("page buffer low byte not loaded");
    a_echo_byte: assert property (
        @(negedge sck) disable iff (link_rst)
        (bc_q == `BIT_B2_END) |=> out_q == sh_q[8:1])
        else $error("byte two not echoed");
    a_bit_count: assert property (
        @(posedge sck) disable iff (link_rst)
        (bc_q == `BIT_FRM_LAST) |=> (bc_q == 5'd0 && frm_q[0] == $past(mosi)))
        else $error("frame alignment lost");

endmodule // serial_program_download

// [rtl/isp_defs.svh]
// constants for the serial programming port: opcodes, frame bit
// positions, memory geometry and self-timed wait figures
`ifndef ISP_DEFS_SVH
`define ISP_DEFS_SVH

`define OP_CFG       8'hac
`define B2_ENABLE    8'h53
`define B2_ERASE     8'h80
`define B2_LOCK      8'he0
`define B2_FUSE_LO   8'ha0
`define B2_FUSE_HI   8'ha8
`define B2_FUSE_EXT  8'ha4
`define B2_FUSE_SEL  8'h08
`define OP_POLL      8'hf0
`define OP_LD_EXT    8'h4d
`define OP_LD_HI     8'h48
`define OP_LD_LO     8'h40
`define OP_LD_EEP    8'hc1
`define OP_RD_HI     8'h28
`define OP_RD_LO     8'h20
`define OP_RD_EEP    8'ha0
`define OP_RD_LOCK   8'h58
`define OP_RD_FUSE   8'h50
`define OP_RD_SIG    8'h30
`define OP_RD_CAL    8'h38
`define OP_WR_PAGE   8'h4c
`define OP_WR_EEP    8'hc0
`define OP_WR_EPAGE  8'hc2

`define BYTE_ERASED  8'hff
`define BYTE_ZERO    8'h00
`define BIT_B2_END   5'd16
`define BIT_B3_END   5'd24
`define BIT_HDR_LAST 5'd23
`define BIT_FRM_LAST 5'd31

`define FL_WORDS     8192
`define EE_BYTES     1024
`define PG_WORDS     64
`define ERASE_LAST   13'h1fff
`define PG_LAST      6'h3f

`define SYS_MHZ       125
`define FLASH_WAIT_US 4500
`define FUSE_WAIT_US  4500
`define EEP_WAIT_US   3600
`define ERASE_WAIT_US 9000

`endif

// [rtl/isp_pkg.sv]
// types shared by the serial programming port
// assumes nothing beyond a SystemVerilog compiler
package isp_pkg;
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ERASE,
        ST_FCOPY
    } isp_state_t;
endpackage

// [tb/isp_programmer.sv]
// behavioural in-system programmer driving the serial programming pins
// assumes the bench supplies a free-running link base clock lclk
`timescale 1ns/1ps

module isp_programmer (
    // link base clock
    input  wire logic lclk,
    // pins toward the device
    output logic      prog_reset_n,
    output logic      sck,
    output logic      mosi,
    input  wire logic miso
);
    // ticks of lclk per sck phase; the bench raises it for slow frames
    int unsigned phase_ticks = 5;

    // reset pin and serial clock held low from power-up
    initial begin
        prog_reset_n = 1'b0;
        sck          = 1'b0;
        mosi         = 1'b0;
    end

    task automatic ticks(input int n);
        repeat (n) @(posedge lclk);
    endtask

    // power-up wait shortened to keep the run short
    task automatic power_up;
        ticks(20);
    endtask

    // reset pulse well above two cpu cycles, then resync
    task automatic pulse_reset;
        prog_reset_n = 1'b1;
        ticks(8);
        prog_reset_n = 1'b0;
        ticks(8);
    endtask

    // one whole four-byte frame, msb first
    task automatic frame(input  logic [31:0] cmd,
                         output logic [7:0]  echo,
                         output logic [7:0]  ans);
        logic [31:0] rx;
        rx = 32'h0000_0000;
        for (int i = 31; i >= 0; i--) begin
            mosi = cmd[i];
            ticks(phase_ticks);
            sck   = 1'b1;
            rx[i] = miso; // device shifts on falling, so stable here
            // long high after bit 24 so byte four carries the new answer
            ticks((i == 8 && phase_ticks < 8) ? 8 : phase_ticks);
            sck = 1'b0;
        end
        mosi = ~cmd[0]; // no stale level left on the released line
        ticks(12);      // gap lets the frame toggle cross to sys_clk
        echo = rx[15:8];
        ans  = rx[7:0];
    endtask
endmodule // isp_programmer

// [tb/serial_program_download_test.sv]
// self-checking bench for the serial programming port
// assumes the design files and isp_programmer are compiled first
`timescale 1ns/1ps

module serial_program_download_test;
    logic       sys_clk = 1'b0;
    logic       lclk    = 1'b0;
    logic       reset   = 1'b1;
    logic       ce      = 1'b1;
    logic       prog_reset_n, sck, mosi, miso;
    logic       prog_enabled, pending_operation_flag;
    logic [7:0] lock_bits, fuse_low, fuse_high, fuse_ext, echo, ans;
    int         error_cnt = 0;
    int         cmp_count = 0;
    int         cyc       = 0;

    always #4 sys_clk = ~sys_clk;
    // 6 ns link base, phase unrelated to sys_clk
    initial begin
        #1.3;
        forever #3 lclk = ~lclk;
    end

    // short self-timed waits; first identity byte arbitrary, the
    // other identity bytes stay at the block's defaults
    serial_program_download #(
        .FLASH_WAIT_CYC (100),
        .FUSE_WAIT_CYC  (100),
        .EEP_WAIT_CYC   (100),
        .ERASE_WAIT_CYC (100),
        .SIG_0          (8'h11)
    ) i_dut (
        .sys_clk                (sys_clk),
        .reset                  (reset),
        .ce                     (ce),
        .prog_reset_n           (prog_reset_n),
        .sck                    (sck),
        .mosi                   (mosi),
        .miso                   (miso),
        .prog_enabled           (prog_enabled),
        .pending_operation_flag (pending_operation_flag),
        .lock_bits              (lock_bits),
        .fuse_low               (fuse_low),
        .fuse_high              (fuse_high),
        .fuse_ext               (fuse_ext)
    );

    isp_programmer i_prog (
        .lclk         (lclk),
        .prog_reset_n (prog_reset_n),
        .sck          (sck),
        .mosi         (mosi),
        .miso         (miso)
    );

    task automatic check(input string what, input logic [7:0] seen,
                         input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic xfer(input logic [31:0] c);
        i_prog.frame(c, echo, ans);
    endtask

    // bounded busy poll; a stuck flag shows as a mismatch
    task automatic poll_wait;
        for (int n = 0; n < 200; n++) begin
            xfer(32'hf000_0000);
            if (ans === 8'h00) break;
        end
        check("poll status", ans, 8'h00);
    endtask

    task automatic t_locked;
        xfer(32'hace0_0000);
        check("lock before enable", lock_bits, 8'hff);
        check("enabled early", {7'h0, prog_enabled}, 8'h00);
        xfer(32'h5800_0000);
        check("lock read", ans, 8'hff);
        $display("test locked done");
    endtask

    task automatic t_enable;
        xfer(32'hac53_0000);
        check("enable echo", echo, 8'h53);
        check("enabled", {7'h0, prog_enabled}, 8'h01);
        $display("test enable done");
    endtask

    task automatic t_erase;
        xfer(32'hac80_0000);
        xfer(32'hf000_0000);
        check("poll busy", ans, 8'h01);
        check("pending", {7'h0, pending_operation_flag}, 8'h01);
        poll_wait;
        xfer(32'h2001_4700);
        check("flash erased", ans, 8'hff);
        xfer(32'ha003_ff00);
        check("eeprom erased", ans, 8'hff);
        $display("test erase done");
    endtask

    task automatic t_flash;
        i_prog.phase_ticks = 12;
        xfer(32'h4000_c5a7); // only six low bits pick the word
        xfer(32'h4800_c55e);
        xfer(32'h4c01_4700); // any word inside the page commits it
        poll_wait;
        i_prog.phase_ticks = 5;
        xfer(32'h2001_4500);
        check("flash low", ans, 8'ha7);
        xfer(32'h2801_4500);
        check("flash high", ans, 8'h5e);
        xfer(32'h2800_8500);
        check("other page", ans, 8'hff);
        $display("test flash done");
    endtask

    task automatic t_eeprom;
        logic [7:0] exp [4];
        exp = '{8'h3c, 8'h11, 8'hff, 8'h33};
        xfer(32'hc002_043c);
        poll_wait;
        xfer(32'hc100_0111);
        xfer(32'hc100_0733); // two low bits give index three
        xfer(32'hc202_0400);
        poll_wait;
        for (int i = 0; i < 4; i++) begin
            xfer({16'ha002, 8'h04 + 8'(i), 8'h00});
            check("eeprom page", ans, exp[i]);
        end
        $display("test eeprom done");
    endtask

    // ce low must freeze the wait timer, so the pending flag holds
    task automatic t_freeze;
        xfer(32'hc000_105a);
        @(negedge sys_clk);
        ce = 1'b0;
        repeat (300) @(negedge sys_clk);
        check("frozen", {7'h0, pending_operation_flag}, 8'h01);
        ce = 1'b1;
        poll_wait;
        xfer(32'ha000_1000);
        check("eeprom byte", ans, 8'h5a);
        $display("test freeze done");
    endtask

    task automatic t_config;
        logic [31:0] tab [4];
        logic [7:0]  pins [4];
        logic [7:0]  sig  [3];
        // first byte overridden above, the others are the defaults
        sig = '{8'h11, 8'h01, 8'h02};
        tab = '{32'ha0e2_5000, 32'ha8d9_5808, 32'ha4fd_5008, 32'he0fc_5800};
        for (int i = 0; i < 4; i++) begin
            xfer({8'hac, tab[i][31:24], 8'h00, tab[i][23:16]});
            poll_wait;
            xfer({tab[i][15:0], 16'h0000});
            check("config read", ans, tab[i][23:16]);
        end
        pins = '{fuse_low, fuse_high, fuse_ext, lock_bits};
        for (int i = 0; i < 4; i++)
            check("config pins", pins[i], tab[i][23:16]);
        for (int i = 0; i < 3; i++) begin
            xfer({24'h3000_00 + 24'(i), 8'h00});
            check("signature", ans, sig[i]);
        end
        xfer(32'h3800_0000);
        check("calibration", ans, 8'h80);
        $display("test config done");
    endtask

    task automatic t_resync;
        i_prog.pulse_reset;
        check("enable dropped", {7'h0, prog_enabled}, 8'h00);
        xfer(32'hace0_0000);
        check("lock refused", lock_bits, 8'hfc);
        xfer(32'hac53_0000);
        check("resync echo", echo, 8'h53);
        xfer(32'h4d00_0100);
        check("ext address", ans, 8'h00);
        $display("test resync done");
    endtask

    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // run ceiling well above the expected length of all tests
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 60000) begin
            error_cnt++;
            print_verdict;
        end
    end

    initial begin
        repeat (10) @(posedge sys_clk);
        @(negedge sys_clk);
        reset = 1'b0;
        i_prog.power_up;
        t_locked;
        t_enable;
        t_erase;
        t_flash;
        t_eeprom;
        t_freeze;
        t_config;
        t_resync;
        print_verdict;
    end
endmodule // serial_program_download_test
